// ---- src/iab_pkg.sv ----
`default_nettype none
package iab_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [31:0] IAB_ADR_CAUSE = 32'h5000_1380;
   localparam logic [31:0] IAB_ADR_CTRL = 32'h5000_13c0;
   localparam logic [31:0] IAB_ADR_TGT = 32'h5000_13c4;
   localparam logic [31:0] IAB_ADR_CLR = 32'h5000_13c8;
   localparam logic [31:0] IAB_ADR_IST = 32'h5000_13cc;
   localparam logic [31:0] IAB_ADR_IMSK = 32'h5000_13d0;

   // ----------------------------------------
   // cause register bit positions
   // ----------------------------------------
   localparam int IAB_B_NARROW = 0;
   localparam int IAB_B_WIDE1 = 1;
   localparam int IAB_B_WIDE2 = 2;
   localparam int IAB_B_DATA = 3;
   localparam int IAB_B_GC_NACK = 4;
   localparam int IAB_B_GC_READ = 5;
   localparam int IAB_B_HS_ACK = 6;
   localparam int IAB_B_SB_ACK = 7;
   localparam int IAB_B_HS_NORS = 8;
   localparam int IAB_B_SB_NORS = 9;

   // ----------------------------------------
   // controller_config, target and interrupt status fields
   // ----------------------------------------
   localparam int IAB_C_MASTER = 0;
   localparam int IAB_C_SPEED = 1;
   localparam int IAB_C_WIDE = 4;
   localparam int IAB_C_RESTART = 5;
   localparam logic [1:0] IAB_SPEED_HS = 2'h3;
   localparam int IAB_T_GCS = 10;
   localparam int IAB_T_SEL = 11;
   localparam int IAB_I_ABORT = 0;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] IAB_CAUSE_RST = 16'h0000;
   localparam logic [15:0] IAB_CTRL_RST = 16'h0023;
   localparam logic [15:0] IAB_TGT_RST = 16'h0000;
   localparam logic [15:0] IAB_IST_RST = 16'h0000;
   localparam logic [15:0] IAB_IMSK_RST = 16'h0000;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // events from the master engine, one-cycle pulses
   typedef struct packed {
      logic cmd_issue;
      logic cmd_read;
      logic addr_nack;
      logic addr_second;
      logic data_nack;
      logic sbyte_ack;
      logic hs_ack;
   } iab_evt_t;

   // configuration toward the master engine
   typedef struct packed {
      logic master_en;
      logic [1:0] speed;
      logic wide_addr;
      logic repeat_start_allow;
      logic target_select_a;
      logic general_call_or_start_byte;
   } iab_cfg_t;

endpackage
`default_nettype wire

// ---- src/iab_abort_flags.sv ----
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module iab_abort_flags
   import iab_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire iab_evt_t evt_i,
   output iab_cfg_t cfg_o,
   output logic [15:0] abort_cause_o,
   output logic irq_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // word address match
   function automatic logic hit(
      input logic [31:0] adr,
      input logic [31:0] off
   );
      hit = (adr[31:2] == off[31:2]);
   endfunction

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [31:0] dat,
      input logic [3:0] sel
   );
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = dat[15:8];
      end
      merge = res;
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------

   // bus side
   logic ack_r;
   logic [31:0] dat_r;
   logic req;
   logic wr_do;
   logic [15:0] wr_lane;
   logic [15:0] rd_val;

   // write strobes, one per writable register
   logic wr_ctrl;
   logic wr_tgt;
   logic wr_clr;
   logic wr_ist;
   logic wr_imsk;

   // software registers
   logic [15:0] ctrl_r;
   logic [15:0] tgt_r;
   logic [15:0] imsk_r;

   // cause flags and their update terms
   logic [15:0] cause_r;
   logic [15:0] cause_nxt;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic refire_r;

   // interrupt status and output
   logic [15:0] ist_r;
   logic [15:0] ist_nxt;
   logic [15:0] ist_set;
   logic [15:0] ist_clr;
   logic irq_r;

   // decoded modes
   logic master;
   logic restart_off;
   logic sb_mode;
   logic gc_mode;
   logic hs_mode;
   logic wide;
   logic sb_cause;
   logic addr_miss;

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------

   // request seen, write done at the ack edge
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_do = req & wb_we_i & ack_r;
   assign wr_lane = merge(16'h0000, wb_dat_i, wb_sel_i);

   // ----------------------------------------
   // write strobes
   // ----------------------------------------

   // one strobe per writable register, each lands at the ack edge only
   assign wr_ctrl = wr_do & hit(wb_adr_i, IAB_ADR_CTRL);
   assign wr_tgt = wr_do & hit(wb_adr_i, IAB_ADR_TGT);
   assign wr_clr = wr_do & hit(wb_adr_i, IAB_ADR_CLR);
   assign wr_ist = wr_do & hit(wb_adr_i, IAB_ADR_IST);
   assign wr_imsk = wr_do & hit(wb_adr_i, IAB_ADR_IMSK);

   // ack one cycle after the request, dropped next
   // a request held past its ack starts a new access and writes again at the next ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // read value selection, unmapped reads zero
   always_comb begin
      rd_val = 16'h0000;
      if (hit(wb_adr_i, IAB_ADR_CAUSE)) begin
         rd_val = cause_r;
      end else if (hit(wb_adr_i, IAB_ADR_CTRL)) begin
         rd_val = ctrl_r;
      end else if (hit(wb_adr_i, IAB_ADR_TGT)) begin
         rd_val = tgt_r;
      end else if (hit(wb_adr_i, IAB_ADR_IST)) begin
         rd_val = ist_r;
      end else if (hit(wb_adr_i, IAB_ADR_IMSK)) begin
         rd_val = imsk_r;
      end else if (hit(wb_adr_i, IAB_ADR_CLR)) begin
         rd_val = 16'h0000; // clear register is write only
      end
   end

   // read data captured with the ack
   // taken on the request edge so it stands through the ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else if (req & ~ack_r & ~wb_we_i) begin
         dat_r <= {16'h0000, rd_val};
      end
   end

   // bus answers straight from their flops
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------

   // controller_config
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= IAB_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
      end
   end

   // target_address_config
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tgt_r <= IAB_TGT_RST;
      end else if (wr_tgt) begin
         tgt_r <= merge(tgt_r, wb_dat_i, wb_sel_i);
      end
   end

   // interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         imsk_r <= IAB_IMSK_RST;
      end else if (wr_imsk) begin
         imsk_r <= merge(imsk_r, wb_dat_i, wb_sel_i);
      end
   end

   // configuration toward the engine
   assign cfg_o.master_en = ctrl_r[IAB_C_MASTER];
   assign cfg_o.speed = ctrl_r[IAB_C_SPEED +: 2];
   assign cfg_o.wide_addr = ctrl_r[IAB_C_WIDE];
   assign cfg_o.repeat_start_allow = ctrl_r[IAB_C_RESTART];
   assign cfg_o.target_select_a = tgt_r[IAB_T_SEL];
   assign cfg_o.general_call_or_start_byte = tgt_r[IAB_T_GCS];

   // ----------------------------------------
   // mode decode
   // ----------------------------------------

   // modes as the engine sees them
   assign master = ctrl_r[IAB_C_MASTER];
   assign restart_off = ~ctrl_r[IAB_C_RESTART];
   assign wide = ctrl_r[IAB_C_WIDE];
   assign hs_mode = (ctrl_r[IAB_C_SPEED +: 2] == IAB_SPEED_HS);

   // target select with the general call bit picks start byte or general call
   assign sb_mode = tgt_r[IAB_T_SEL] & tgt_r[IAB_T_GCS];
   assign gc_mode = tgt_r[IAB_T_SEL] & ~tgt_r[IAB_T_GCS];

   // start byte cause persists while all of its terms hold
   assign sb_cause = master & restart_off & sb_mode;

   // unanswered address outside a general call, shared by flags 2, 1 and 0
   assign addr_miss = evt_i.addr_nack & master & ~gc_mode;

   // ----------------------------------------
   // cause flags
   // ----------------------------------------

   // set terms, one per flag
   always_comb begin
      set_v = 16'h0000;

      // start byte command while repeat start is off, or the re-assert
      set_v[IAB_B_SB_NORS] = (evt_i.cmd_issue & sb_cause) | refire_r;

      // high-speed command while repeat start is off
      set_v[IAB_B_HS_NORS] = evt_i.cmd_issue & master & restart_off
         & hs_mode;

      // start byte answered by some slave
      set_v[IAB_B_SB_ACK] = evt_i.sbyte_ack & master & sb_mode;

      // high-speed master code answered
      set_v[IAB_B_HS_ACK] = evt_i.hs_ack & master & hs_mode;

      // read queued right behind a general call
      set_v[IAB_B_GC_READ] = evt_i.cmd_issue & evt_i.cmd_read & master
         & gc_mode;

      // general call left unanswered
      set_v[IAB_B_GC_NACK] = evt_i.addr_nack & master & gc_mode;

      // data byte after an answered address left unanswered
      set_v[IAB_B_DATA] = evt_i.data_nack & master;

      // second and first byte of a wide address left unanswered
      set_v[IAB_B_WIDE2] = addr_miss & wide & evt_i.addr_second;
      set_v[IAB_B_WIDE1] = addr_miss & wide & ~evt_i.addr_second;

      // narrow address left unanswered
      set_v[IAB_B_NARROW] = addr_miss & ~wide;
   end

   // software clear, a one clears the bit
   assign clr_v = wr_clr ? wr_lane : 16'h0000;

   // sticky flags, a set wins over a clear
   assign cause_nxt = set_v | (cause_r & ~clr_v);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_r <= IAB_CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // re-assert flag 9 one cycle after a clear that left its cause
   // the clear wins for one cycle, then the live cause wins again
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refire_r <= 1'b0;
      end else begin
         refire_r <= clr_v[IAB_B_SB_NORS] & cause_r[IAB_B_SB_NORS]
            & ~set_v[IAB_B_SB_NORS] & sb_cause;
      end
   end

   // flags straight from their flops
   assign abort_cause_o = cause_r;

   // ----------------------------------------
   // interrupt
   // ----------------------------------------

   // abort event when any flag newly rises
   // a repeat of a flag already set is no new event
   always_comb begin
      ist_set = 16'h0000;
      ist_set[IAB_I_ABORT] = |(set_v & ~cause_r);
   end

   // write one to clear a status bit
   assign ist_clr = wr_ist ? wr_lane : 16'h0000;

   // sticky status, set wins over clear
   assign ist_nxt = ist_set | (ist_r & ~ist_clr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_r <= IAB_IST_RST;
      end else begin
         ist_r <= ist_nxt;
      end
   end

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------

   // level output from a flop
   // next status is used so the level follows status with no lag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(ist_nxt & imsk_r);
      end
   end

   // level interrupt toward the system
   assign irq_o = irq_r;

endmodule
`default_nettype wire

// ---- sim/iab_abort_flags_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module iab_abort_flags_sva
   import iab_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire iab_evt_t evt_i,
   input wire iab_cfg_t cfg_o,
   input wire logic [15:0] abort_cause_o
);
   // ----
   // mode shorthands
   // ----
   wire logic m = cfg_o.master_en;
   wire logic nr = m && !cfg_o.repeat_start_allow;
   wire logic sg = cfg_o.target_select_a && cfg_o.general_call_or_start_byte;
   wire logic gc = cfg_o.target_select_a && !cfg_o.general_call_or_start_byte;
   wire logic hs = cfg_o.speed == IAB_SPEED_HS;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----
   // checks
   // ----
   sb_norst_a: assert property (evt_i.cmd_issue && nr && sg |=> abort_cause_o[9])
      else $error("flag 9 missing");
   hs_norst_a: assert property (evt_i.cmd_issue && nr && hs |=> abort_cause_o[8])
      else $error("flag 8 missing");
   sb_acked_a: assert property (evt_i.sbyte_ack && m && sg |=> abort_cause_o[7])
      else $error("flag 7 missing");
   hs_acked_a: assert property (evt_i.hs_ack && m && hs |=> abort_cause_o[6])
      else $error("flag 6 missing");
   data_nack_a: assert property (evt_i.data_nack && m |=> abort_cause_o[3])
      else $error("flag 3 missing");
   narrow_nack_a: assert property (evt_i.addr_nack && m && !gc && !cfg_o.wide_addr
      |=> abort_cause_o[0])
      else $error("flag 0 missing");
   flags_hold_a: assert property (!(wb_cyc_i && wb_stb_i)
      |=> (abort_cause_o & $past(abort_cause_o)) == $past(abort_cause_o))
      else $error("flag dropped without clear");
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing wrong");
endmodule
bind iab_abort_flags iab_abort_flags_sva u_sva(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .evt_i, .cfg_o, .abort_cause_o);
`default_nettype wire

// ---- sim/iab_slave_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module iab_slave_model
   import iab_pkg::*;
(
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [6:0] ev_i,
   output var iab_evt_t evt_o
);
   // quiet until the first request
   initial evt_o = '0;
   // one-cycle report of how the remote slaves answered
   always @(posedge clk_i) begin
      evt_o <= go_i ? iab_evt_t'(ev_i) : '0;
   end
endmodule
`default_nettype wire

// ---- sim/iab_abort_flags_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module iab_abort_flags_bench
   import iab_pkg::*;
();
   // ----
   // stimulus state and tables
   // ----
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, ack, irq;
   logic [31:0] adr = 0, dat = 0, rd, wdo;
   logic [3:0] sel = 0;
   logic [6:0] ev = 0;
   logic [15:0] cause;
   iab_evt_t evt;
   iab_cfg_t cfg;
   int num_errors = 0, compares = 0, k, r, n;
   logic [15:0] ctl [10] = '{16'h21, 16'h31, 16'h31, 16'h21, 16'h21, 16'h21, 16'h27,
      16'h21, 16'h07, 16'h01};
   logic [15:0] tgt [10] = '{0, 0, 0, 0, 16'h800, 16'h800, 0, 16'hc00, 0, 16'hc00};
   logic [6:0] evs [10] = '{7'h10, 7'h10, 7'h18, 7'h04, 7'h10, 7'h60, 7'h01, 7'h02,
      7'h40, 7'h40};
   logic [31:0] ra [6] = '{IAB_ADR_CAUSE, IAB_ADR_CTRL, IAB_ADR_TGT, IAB_ADR_IST,
      IAB_ADR_IMSK, 32'h5000_13fc};
   logic [15:0] rv [6] = '{IAB_CAUSE_RST, IAB_CTRL_RST, IAB_TGT_RST, IAB_IST_RST,
      IAB_IMSK_RST, 16'h0};
   iab_abort_flags u_dut(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo),
      .wb_ack_o(ack), .evt_i(evt), .cfg_o(cfg), .abort_cause_o(cause), .irq_o(irq));
   iab_slave_model u_slv(.clk_i(clk_i), .go_i(go), .ev_i(ev), .evt_o(evt));
   // 25 MHz clock
   initial forever #20 clk_i = ~clk_i;
   // ----
   // helpers
   // ----
   function automatic logic [31:0] exp_bit(input int i);
      return 32'h1 << i;
   endfunction
   function automatic logic [6:0] cfg_exp(input logic [15:0] c, input logic [15:0] t);
      return {c[IAB_C_MASTER], c[IAB_C_SPEED +: 2], c[IAB_C_WIDE], c[IAB_C_RESTART],
         t[IAB_T_SEL], t[IAB_T_GCS]};
   endfunction
   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int t;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h3;
      t = 0;
      do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 20);
      if (ack !== 1'b1) begin num_errors++; end_of_test(); end
      rd = wdo;
      cyc <= 0; stb <= 0;
   endtask
   task automatic fire(input logic [6:0] e);
      @(posedge clk_i); go <= 1; ev <= e;
      @(posedge clk_i); go <= 0;
      repeat (3) @(posedge clk_i);
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      r = $urandom(32'hd12dffb8);
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      xfer(1, IAB_ADR_CAUSE, $urandom);
      xfer(1, 32'h5000_13fc, $urandom);
      for (k = 0; k < 6; k++) begin
         xfer(0, ra[k], 0); `CHK("reg", {16'h0, rv[k]}, rd)
      end
      $display("test reset done");
      r = $urandom % 10;
      for (k = 0; k < 10; k++) begin
         n = (r + k) % 10;
         xfer(1, IAB_ADR_CTRL, ctl[n]);
         xfer(1, IAB_ADR_TGT, tgt[n]);
         xfer(1, IAB_ADR_CLR, 32'h3ff);
         `CHK("cfg", cfg_exp(ctl[n], tgt[n]), cfg)
         fire(evs[n]);
         xfer(0, IAB_ADR_CAUSE, 0);
         `CHK("cause", exp_bit(n), rd)
      end
      $display("test causes done");
      xfer(1, IAB_ADR_CLR, 32'h3ff);
      xfer(1, IAB_ADR_CTRL, 16'h01);
      xfer(1, IAB_ADR_TGT, 16'hc00);
      fire(7'h40);
      xfer(1, IAB_ADR_CLR, 32'h200);
      @(posedge clk_i); `CHK("drop", 1'b0, cause[9])
      @(posedge clk_i); `CHK("back", 1'b1, cause[9])
      xfer(1, IAB_ADR_CTRL, 16'h21); xfer(1, IAB_ADR_CLR, 32'h200);
      xfer(0, IAB_ADR_CAUSE, 0); `CHK("fixed", 32'h0, rd)
      $display("test clear done");
      xfer(1, IAB_ADR_IST, 1); xfer(1, IAB_ADR_IMSK, 1);
      fire(7'h10);
      `CHK("irq", 1'b1, irq)
      xfer(0, IAB_ADR_IST, 0); `CHK("ist", 32'h1, rd)
      xfer(1, IAB_ADR_IST, 1);
      repeat (2) @(posedge clk_i); `CHK("irq", 1'b0, irq)
      xfer(1, IAB_ADR_IMSK, 0); xfer(1, IAB_ADR_CLR, 32'h3ff);
      fire(7'h10);
      `CHK("masked", 1'b0, irq)
      xfer(0, IAB_ADR_IST, 0);
      `CHK("ist", 32'h1, rd)
      $display("test irq done");
      end_of_test();
   end
endmodule
`default_nettype wire
